// File: hdl/lviw_core.sv
// Low-voltage interrupt request, vectoring and wake-up logic
`include "lviw_regs.svh"
module lviw_core
    import lviw_pkg::*;
(
    // Clock and reset
    input  wire logic                   CLK_I,
    input  wire logic                   RESET_N_I,
    // Detector pin and other flags
    input  wire logic                   SUPPLY_DROP_DETECTOR_I,
    input  wire logic                   OTHER_FLAGS_RISE_I,
    // Core side
    input  wire lviw_ctl_type           CTL_I,
    input  wire logic [`LVIW_PC_W-1:0]  PC_I,
    input  wire logic                   STACK_FULL_I,
    input  wire logic                   SLEEP_I,
    // Results
    output logic                        LOW_VOLTAGE_REQUEST_FLAG_O,
    output logic                        GLOBAL_IRQ_ENABLE_O,
    output logic                        LOW_VOLTAGE_IRQ_ENABLE_O,
    output logic                        VECTOR_CALL_O,
    output logic [`LVIW_PC_W-1:0]       VECTOR_ADDR_O,
    output logic                        PUSH_O,
    output logic [`LVIW_PC_W-1:0]       PUSH_DATA_O,
    output logic                        POP_O,
    output logic                        WAKE_O,
    output logic                        IN_SERVICE_O
);
    logic [2:0]      sync_q;
    logic            det_q;
    logic            flag_q;
    logic            flag_d;
    logic            gie_q;
    logic            gie_d;
    logic            lie_q;
    logic            lie_d;
    logic            take;
    logic            det_rise;
    lviw_state_type  state_q;

    // Detector is asynchronous; stage two and three must agree
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            sync_q <= `LVIW_SYNC_RST;
            det_q  <= 1'b0;
        end else begin
            sync_q <= {sync_q[1:0], SUPPLY_DROP_DETECTOR_I};
            if (sync_q[1] == sync_q[2]) begin
                det_q <= sync_q[2];
            end
        end
    end

    assign det_rise = (sync_q[1] == sync_q[2]) && sync_q[2] && !det_q;

    // Taken only in run state, so one entry per request
    assign take = flag_q && gie_q && lie_q
                  && !STACK_FULL_I
                  && (state_q == LVIW_RUN);

    // Flag: detector level sets, set wins over any clear
    always_comb begin
        flag_d = flag_q;
        if (take || CTL_I.clr_flag) begin
            flag_d = 1'b0;
        end
        if (det_q || det_rise || CTL_I.set_flag) begin
            flag_d = 1'b1;
        end
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            flag_q <= `LVIW_FLAG_RST;
        end else begin
            flag_q <= flag_d;
        end
    end

    // Global enable: entry beats any write; set beats clear
    always_comb begin
        gie_d = gie_q;
        if (CTL_I.clr_gie) begin
            gie_d = 1'b0;
        end
        if (CTL_I.return_and_rearm || CTL_I.set_gie) begin
            gie_d = 1'b1;
        end
        if (take) begin
            gie_d = 1'b0;
        end
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            gie_q <= `LVIW_GIE_RST;
        end else begin
            gie_q <= gie_d;
        end
    end

    // Local enable; clearing it never touches the flag
    always_comb begin
        lie_d = lie_q;
        if (CTL_I.clr_lie) begin
            lie_d = 1'b0;
        end
        if (CTL_I.set_lie) begin
            lie_d = 1'b1;
        end
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            lie_q <= `LVIW_LIE_RST;
        end else begin
            lie_q <= lie_d;
        end
    end

    // Service sequence
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            state_q <= LVIW_RUN;
        end else begin
            unique case (state_q)
                LVIW_RUN: begin
                    if (take) begin
                        state_q <= LVIW_ENTER;
                    end
                end
                LVIW_ENTER: begin
                    state_q <= LVIW_SVC;
                end
                LVIW_SVC: begin
                    if (CTL_I.return_and_rearm || CTL_I.subroutine_return) begin
                        state_q <= LVIW_RUN;
                    end
                end
                default: begin
                    state_q <= LVIW_RUN;
                end
            endcase
        end
    end

    // Call, push and pop strobes
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            VECTOR_CALL_O <= 1'b0;
            VECTOR_ADDR_O <= '0;
            PUSH_O        <= 1'b0;
            PUSH_DATA_O   <= '0;
            POP_O         <= 1'b0;
        end else begin
            VECTOR_CALL_O <= take;
            VECTOR_ADDR_O <= `LVIW_VECTOR;
            PUSH_O        <= take;
            if (take) begin
                PUSH_DATA_O <= PC_I;
            end
            // Either return pops; only rearming one restores enable
            POP_O <= CTL_I.return_and_rearm
                     || CTL_I.subroutine_return;
        end
    end

    // Wake on rising flag only while asleep; enables ignored
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            WAKE_O <= 1'b0;
        end else begin
            WAKE_O <= SLEEP_I && ((flag_d && !flag_q)
                      || OTHER_FLAGS_RISE_I);
        end
    end

    // Mirrors of state
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            LOW_VOLTAGE_REQUEST_FLAG_O <= 1'b0;
            GLOBAL_IRQ_ENABLE_O        <= 1'b0;
            LOW_VOLTAGE_IRQ_ENABLE_O   <= 1'b0;
            IN_SERVICE_O               <= 1'b0;
        end else begin
            LOW_VOLTAGE_REQUEST_FLAG_O <= flag_d;
            // Next values, so outputs track the enables without lag
            GLOBAL_IRQ_ENABLE_O        <= gie_d;
            LOW_VOLTAGE_IRQ_ENABLE_O   <= lie_d;
            IN_SERVICE_O               <= (state_q != LVIW_RUN) || take;
        end
    end
endmodule : lviw_core

// File: hdl/lviw_pkg.sv
// Types shared by the low-voltage interrupt and wake-up block
`include "lviw_regs.svh"
package lviw_pkg;
    typedef enum logic [1:0] {
        LVIW_RUN   = 2'b00,
        LVIW_ENTER = 2'b01,
        LVIW_SVC   = 2'b11
    } lviw_state_type;

    // Core requests toward the block
    typedef struct packed {
        logic set_flag;
        logic clr_flag;
        logic set_gie;
        logic clr_gie;
        logic set_lie;
        logic clr_lie;
        logic subroutine_return;
        logic return_and_rearm;
        logic sleep_enter;
    } lviw_ctl_type;
endpackage : lviw_pkg

// File: hdl/lviw_regs.svh
// Constants of the low-voltage interrupt and wake-up block
`ifndef LVIW_REGS_SVH
`define LVIW_REGS_SVH
`define LVIW_PC_W        13
`define LVIW_VECTOR      13'h0014
`define LVIW_FLAG_RST    1'b0
`define LVIW_GIE_RST     1'b0
`define LVIW_LIE_RST     1'b0
`define LVIW_SYNC_RST    3'h0
`endif

// File: test/low_voltage_interrupt_wakeup_bench.sv
// Self-checking bench for the low-voltage interrupt block
`include "lviw_regs.svh"
module low_voltage_interrupt_wakeup_bench import lviw_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst_n = 0, det = 0, oth = 0, slp = 0, bcall = 0, bret = 0;
    lviw_ctl_type           ctl = '0;
    logic [`LVIW_PC_W-1:0]  pc, push_d, addr;
    logic                   flag, gie, lie, call, push, pop, wake, svc, full;
    int                     failures, n_tests, cyc, wakes, calls, m_gie, r;
    int                     seed = 18881;
    always #12.5 clk = ~clk;
    lviw_core dut_u (.CLK_I(clk), .RESET_N_I(rst_n),
        .SUPPLY_DROP_DETECTOR_I(det), .OTHER_FLAGS_RISE_I(oth), .CTL_I(ctl),
        .PC_I(pc), .STACK_FULL_I(full), .SLEEP_I(slp),
        .LOW_VOLTAGE_REQUEST_FLAG_O(flag), .GLOBAL_IRQ_ENABLE_O(gie),
        .LOW_VOLTAGE_IRQ_ENABLE_O(lie), .VECTOR_CALL_O(call),
        .VECTOR_ADDR_O(addr), .PUSH_O(push), .PUSH_DATA_O(push_d),
        .POP_O(pop), .WAKE_O(wake), .IN_SERVICE_O(svc));
    lviw_seq #(.DEPTH(1)) seq_u (.clk_i(clk), .rst_n_i(rst_n),
        .push_i(push | bcall), .pop_i(pop | bret), .full_o(full), .pc_o(pc));
    task chk(input logic [`LVIW_PC_W-1:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task give_verdict();
        $display("Checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : give_verdict
    task step(input int n);
        repeat (n) @(posedge clk);
    endtask : step
    // One-cycle core request, then a quiet cycle so pulses never merge
    task pulse(input int b);
        ctl <= lviw_ctl_type'(9'h1 << b);
        step(1);
        ctl <= '0;
        step(1);
    endtask : pulse
    task service(input int rearm);
        for (int k = 0; k < 20 && call !== 1'b1; k++) step(1);
        chk(call, 1'b1);
        chk(push_d, pc - 1'b1);
        chk(addr, `LVIW_VECTOR);
        chk(flag, 1'b0);
        chk(gie, 1'b0);
        chk(svc, 1'b1);
        chk(lie, 1'b1);
        m_gie = rearm;
        pulse(rearm ? 1 : 2);
        chk(pop, 1'b1);
        chk(gie, m_gie[0]);
    endtask : service
    always @(negedge clk) begin
        wakes += wake;
        calls += call;
        cyc++;
        if (cyc == 2000) begin
            failures++;
            give_verdict();
        end
    end
    initial begin
        step(6);
        rst_n <= 1'b1;
        step(2);
        chk({flag, gie, lie, call}, 4'h0);
        pulse(8);
        pulse(4);
        bcall <= 1'b1;
        step(1);
        bcall <= 1'b0;
        pulse(6);
        step(4);
        chk(calls, 0);
        chk(flag, 1'b1);
        bret <= 1'b1;
        step(1);
        bret <= 1'b0;
        service(1);
        repeat (6) begin
            r = $random(seed);
            if (m_gie == 0) pulse(6);
            step(r[2:0]);
            pulse(8);
            service(r[3]);
        end
        pulse(5);
        det <= 1'b1;
        step(8);
        chk(flag, 1'b1);
        det <= 1'b0;
        pulse(3);
        step(5);
        chk(flag, 1'b1);
        pulse(7);
        chk(flag, 1'b0);
        slp <= 1'b1;
        r = wakes;
        pulse(8);
        step(3);
        chk(wakes - r, 1);
        slp <= 1'b0;
        step(1);
        slp <= 1'b1;
        r = wakes;
        step(6);
        chk(wakes - r, 0);
        oth <= 1'b1;
        step(1);
        oth <= 1'b0;
        step(3);
        chk(wakes - r, 1);
        give_verdict();
    end
endmodule : low_voltage_interrupt_wakeup_bench

// File: test/lviw_assertions.sv
// Port checker for the low-voltage interrupt block
module lviw_chk
    import lviw_pkg::*;
(
    input wire logic         CLK_I,
    input wire logic         RESET_N_I,
    input wire logic         OTHER_FLAGS_RISE_I,
    input wire lviw_ctl_type CTL_I,
    input wire logic         STACK_FULL_I,
    input wire logic         SLEEP_I,
    input wire logic         LOW_VOLTAGE_REQUEST_FLAG_O,
    input wire logic         GLOBAL_IRQ_ENABLE_O,
    input wire logic         LOW_VOLTAGE_IRQ_ENABLE_O,
    input wire logic         VECTOR_CALL_O,
    input wire logic         PUSH_O,
    input wire logic         POP_O,
    input wire logic         WAKE_O,
    input wire logic         IN_SERVICE_O
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);
    sequence rearm_s;
        POP_O && GLOBAL_IRQ_ENABLE_O;
    endsequence
    gate_a: assert property (VECTOR_CALL_O |-> $past(GLOBAL_IRQ_ENABLE_O)
        && $past(LOW_VOLTAGE_IRQ_ENABLE_O) && !$past(STACK_FULL_I))
        else $error("call taken without enables or stack room");
    entry_a: assert property (VECTOR_CALL_O |-> PUSH_O && IN_SERVICE_O
        && !GLOBAL_IRQ_ENABLE_O) else $error("bad service entry");
    push_a: assert property (PUSH_O |-> VECTOR_CALL_O)
        else $error("push outside a call");
    once_a: assert property (VECTOR_CALL_O |=> !VECTOR_CALL_O [*2])
        else $error("call repeated during service");
    rearm_a: assert property (IN_SERVICE_O && CTL_I.return_and_rearm
        |=> rearm_s) else $error("rearming return failed");
    plain_a: assert property (IN_SERVICE_O && CTL_I.subroutine_return
        && !CTL_I.set_gie |=> POP_O && !GLOBAL_IRQ_ENABLE_O)
        else $error("plain return failed");
    wake_a: assert property (SLEEP_I && $rose(LOW_VOLTAGE_REQUEST_FLAG_O)
        |-> ##[0:3] WAKE_O) else $error("no wake on flag rise");
    other_a: assert property (SLEEP_I && OTHER_FLAGS_RISE_I
        |-> ##[1:2] WAKE_O) else $error("no wake on other flag");
    hold_a: assert property ($fell(LOW_VOLTAGE_REQUEST_FLAG_O) |->
        (##[0:2] VECTOR_CALL_O) or ($past(VECTOR_CALL_O)
        || $past(CTL_I.clr_flag) || $past(CTL_I.clr_flag, 2)))
        else $error("flag dropped without cause");
endmodule : lviw_chk

bind lviw_core lviw_chk chk_u (.*);

// File: test/lviw_seq.sv
// Partner model: core program counter and one-level stack
`include "lviw_regs.svh"
module lviw_seq #(
    parameter int DEPTH = 1
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_n_i,
    input  wire logic                  push_i,
    input  wire logic                  pop_i,
    output logic                       full_o,
    output logic [`LVIW_PC_W-1:0]      pc_o
);
    timeunit 1ns;
    timeprecision 100ps;
    int lvl_q;
    // Full stack must hold vectoring back
    assign full_o = (lvl_q >= DEPTH);
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lvl_q <= 0;
            pc_o  <= '0;
        end else begin
            lvl_q <= lvl_q + int'(push_i) - int'(pop_i);
            pc_o  <= pc_o + 1'b1;
        end
    end
endmodule : lviw_seq
